// ### rtl/tlas_pkg.sv
`default_nettype none
package tlas_pkg;
   // Clock and conversion timing
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned SLOW_PERIOD_MS  = 16000;
   localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_MS * (CLK_HZ / MS_PER_S);
   localparam logic [3:0]  RATE_FASTEST    = 4'hA;

   // Register addresses
   localparam logic [7:0]  ADDR_STAT1      = 8'h02;
   localparam logic [7:0]  ADDR_CFG_RD     = 8'h03;
   localparam logic [7:0]  ADDR_RATE_RD    = 8'h04;
   localparam logic [7:0]  ADDR_CFG_WR     = 8'h09;
   localparam logic [7:0]  ADDR_RATE_WR    = 8'h0A;
   localparam logic [7:0]  ADDR_HYST       = 8'h21;
   localparam logic [7:0]  ADDR_STAT2      = 8'h23;
   localparam logic [7:0]  ADDR_LIM_BASE   = 8'h40;

   // Reset values
   localparam logic [7:0]  RATE_RST        = 8'h07;
   localparam logic [7:0]  CFG_RST         = 8'h00;
   localparam logic [7:0]  HYST_RST        = 8'h0A;
   localparam logic [7:0]  LIM_RST_HIGH    = 8'h7F;
   localparam logic [7:0]  LIM_RST_LOW     = 8'h00;
   localparam logic [7:0]  LIM_RST_CRIT    = 8'h55;

   // Field masks and bit positions
   localparam logic [7:0]  CFG_WR_MASK     = 8'hEF;
   localparam logic [7:0]  RATE_WR_MASK    = 8'h0F;
   localparam int unsigned CFG_MASK_ALL    = 7;
   localparam int unsigned CFG_STANDBY     = 6;
   localparam int unsigned CFG_PIN8        = 5;
   localparam int unsigned CFG_RANGE       = 2;
   localparam int unsigned CFG_REMOTE_ONE_IRQ_SUPPRESS     = 1;
   localparam int unsigned CFG_REMOTE_TWO_IRQ_SUPPRESS     = 0;

   // Limit bank layout
   localparam int unsigned LIM_NUM         = 13;
   localparam int unsigned LIM_L_HI        = 0;
   localparam int unsigned LIM_L_LO        = 1;
   localparam int unsigned LIM_L_CRIT      = 2;
   localparam int unsigned LIM_R1_BASE     = 3;
   localparam int unsigned LIM_R2_BASE     = 8;
   localparam int unsigned LIM_OFS_HI_MSB  = 0;
   localparam int unsigned LIM_OFS_HI_LSB  = 1;
   localparam int unsigned LIM_OFS_LO_MSB  = 2;
   localparam int unsigned LIM_OFS_LO_LSB  = 3;
   localparam int unsigned LIM_OFS_CRIT    = 4;
   localparam int unsigned NUM_CH          = 3;
   localparam logic [1:0]  FRAC_ZERO       = 2'h0;
endpackage
`default_nettype wire

// ### rtl/tlas_limit_mem.sv
`default_nettype none
module tlas_limit_mem #(
   parameter int unsigned WIDTH   = 8,
   parameter int unsigned DEPTH   = 13,
   parameter logic [WIDTH*DEPTH-1:0] RST_VEC = '0
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
   input  wire logic [WIDTH-1:0]         wr_data_i,
   input  wire logic                     rd_en_i,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
   output logic      [WIDTH-1:0]         rd_data_o,
   output logic      [WIDTH*DEPTH-1:0]   words_o
);
   logic [WIDTH*DEPTH-1:0] mem_q;
   logic [WIDTH*DEPTH-1:0] mem_d;
   logic [WIDTH-1:0]       rd_q;
   logic [WIDTH-1:0]       rd_d;

   initial
   begin
      if (DEPTH < 2 || WIDTH < 1)
      begin
         $error("Limit bank too small");
      end
   end

   // Write one entry, register the read port
   always_comb
   begin
      mem_d = mem_q;
      rd_d  = rd_q;
      if (wr_en_i && 32'(wr_idx_i) < DEPTH)
      begin
         mem_d[wr_idx_i*WIDTH +: WIDTH] = wr_data_i;
      end
      if (rd_en_i)
      begin
         rd_d = (32'(rd_idx_i) < DEPTH) ? mem_q[rd_idx_i*WIDTH +: WIDTH] : '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mem_q <= RST_VEC;
         rd_q  <= '0;
      end
      else
      begin
         mem_q <= mem_d;
         rd_q  <= rd_d;
      end
   end

   // Comparators see every limit at once
   assign rd_data_o = rd_q;
   assign words_o   = mem_q;
endmodule
`default_nettype wire

// ### rtl/tlas_core.sv
// Notes on behaviour
// - Three limits per channel, remote split bytes
// - High trips on greater, low on equal-or-less
// - Critical output low when any critical exceeded
// - One hysteresis value, default ten degrees
// - Critical release below limit minus hysteresis
// - Limits compared raw, never converted on rescale
// - Rate code doubles from 1/16 to 64
// - Status registers ignore writes
// - Primary status bit layout as listed
// - Secondary status bit layout as listed
// - Eight sticky flags, cleared by status read
// - Unmasked flag sets latch, pulls interrupt low
// - Status read clears flags whose cause ended
// - Clear only when value in limits, sensor good
// - Latch survives reads, cleared by alert response
// - Critical flags self-clear, drive critical output
// - Pin 8 critical mode uses high limits only
// - Secondary bit 0 mirrors interrupt output
// - Config bit 5 chooses pin 8 function
// - Config masks: all, remote one, remote two
// - Config bit 2 selects extended range
`default_nettype none
module tlas_core #(
   parameter int unsigned SLOW_PERIOD_CYC = tlas_pkg::SLOW_PERIOD_CYC
) (
   input  wire logic       CLOCK_I,
   input  wire logic       SYS_RST_I,
   input  wire logic [7:0] REG_ADDR_I,
   input  wire logic       REG_WR_I,
   input  wire logic       REG_RD_I,
   input  wire logic [7:0] REG_WDATA_I,
   output logic      [7:0] REG_RDATA_O,
   output logic            REG_RVALID_O,
   input  wire logic       ALERT_ACK_I,
   input  wire logic       CONV_VALID_I,
   input  wire logic [1:0] CONV_CHAN_I,
   input  wire logic [9:0] CONV_TEMP_I,
   input  wire logic       CONV_OPEN_I,
   input  wire logic       CONV_BUSY_I,
   output logic            CONV_START_O,
   output logic            RANGE_EXT_O,
   output logic            STANDBY_O,
   output logic            PIN8_O,
   output logic            PIN8_OE_O,
   output logic            CRITICAL_TEMP_OUT_O,
   output logic            CRITICAL_TEMP_OUT_OE_O
);
   // One spare bit so a power-of-two slow period still fits the counter
   localparam int unsigned CNT_W  = $clog2(SLOW_PERIOD_CYC) + 1;
   localparam int unsigned IDX_W  = $clog2(tlas_pkg::LIM_NUM);
   localparam int unsigned NCH    = tlas_pkg::NUM_CH;

   initial
   begin
      if ((SLOW_PERIOD_CYC >> tlas_pkg::RATE_FASTEST) < 2)
      begin
         $error("Slow period too short for fastest rate");
      end
   end

   // Limit bank reset image
   function automatic logic [8*tlas_pkg::LIM_NUM-1:0] lim_rst_vec();
      logic [8*tlas_pkg::LIM_NUM-1:0] v;
      int unsigned b;
      v = '0;
      v[tlas_pkg::LIM_L_HI*8 +: 8]   = tlas_pkg::LIM_RST_HIGH;
      v[tlas_pkg::LIM_L_LO*8 +: 8]   = tlas_pkg::LIM_RST_LOW;
      v[tlas_pkg::LIM_L_CRIT*8 +: 8] = tlas_pkg::LIM_RST_CRIT;
      for (int r = 0; r < 2; r++)
      begin
         b = (r == 0) ? tlas_pkg::LIM_R1_BASE : tlas_pkg::LIM_R2_BASE;
         v[(b + tlas_pkg::LIM_OFS_HI_MSB)*8 +: 8] = tlas_pkg::LIM_RST_HIGH;
         v[(b + tlas_pkg::LIM_OFS_LO_MSB)*8 +: 8] = tlas_pkg::LIM_RST_LOW;
         v[(b + tlas_pkg::LIM_OFS_CRIT)*8 +: 8]   = tlas_pkg::LIM_RST_CRIT;
      end
      return v;
   endfunction

   logic [7:0]                   cfg_q, cfg_d, rate_q, rate_d, hyst_q, hyst_d;
   logic [7:0]                   rdata_q, rdata_d;
   logic                         rvalid_q, rd_mem_q, rd_d_mem;
   logic                         alert_q, alert_d, start_q, start_d;
   logic [CNT_W-1:0]             cnt_q, cnt_d, period;
   logic [3:0]                   rate_eff;
   logic [8*tlas_pkg::LIM_NUM-1:0] words;
   logic [7:0]                   mem_rdata;
   logic [IDX_W-1:0]             lim_idx;
   logic                         is_lim, rd_s1, rd_s2;
   logic [NCH-1:0]               over_f, under_f, open_f, crit_q, th2_q, eval_v;
   logic [NCH-1:0]               over_v, under_v, crit_v;
   logic                         pin8_th2, mask_all, unmasked;
   logic [7:0]                   stat1, stat2;
   logic [7:0]                   lim_ofs;

   // Address decode; limit window sits above the fixed registers
   assign lim_ofs = REG_ADDR_I - tlas_pkg::ADDR_LIM_BASE;
   assign is_lim  = (REG_ADDR_I >= tlas_pkg::ADDR_LIM_BASE) &&
                    (32'(lim_ofs) < tlas_pkg::LIM_NUM);
   assign lim_idx = lim_ofs[IDX_W-1:0];
   assign rd_s1   = REG_RD_I && REG_ADDR_I == tlas_pkg::ADDR_STAT1;
   assign rd_s2   = REG_RD_I && REG_ADDR_I == tlas_pkg::ADDR_STAT2;

   tlas_limit_mem #(
      .WIDTH   (8),
      .DEPTH   (tlas_pkg::LIM_NUM),
      .RST_VEC (lim_rst_vec())
   ) u_limits (
      .clk_i     (CLOCK_I),
      .rst_i     (SYS_RST_I),
      .wr_en_i   (REG_WR_I && is_lim),
      .wr_idx_i  (lim_idx),
      .wr_data_i (REG_WDATA_I),
      .rd_en_i   (REG_RD_I && is_lim),
      .rd_idx_i  (lim_idx),
      .rd_data_o (mem_rdata),
      .words_o   (words)
   );

   assign pin8_th2 = cfg_q[tlas_pkg::CFG_PIN8];
   assign mask_all = cfg_q[tlas_pkg::CFG_MASK_ALL];

   // Per-channel comparators and flags; limits used as stored bytes
   for (genvar ch = 0; ch < NCH; ch++)
   begin : g_ch
      logic [9:0]  hi10, lo10, crit10;
      logic [10:0] meas_h;
      logic        over_f_d, under_f_d, open_f_d, crit_d, th2_d;
      logic        over_c, under_c, open_c, over_cq, under_cq, open_cq;
      logic        clr, crit_rel, th2_rel;
      if (ch == 0)
      begin : g_loc
         assign hi10   = {words[tlas_pkg::LIM_L_HI*8 +: 8], tlas_pkg::FRAC_ZERO};
         assign lo10   = {words[tlas_pkg::LIM_L_LO*8 +: 8], tlas_pkg::FRAC_ZERO};
         assign crit10 = {words[tlas_pkg::LIM_L_CRIT*8 +: 8], tlas_pkg::FRAC_ZERO};
      end
      else
      begin : g_rem
         localparam int unsigned B = (ch == 1) ? tlas_pkg::LIM_R1_BASE : tlas_pkg::LIM_R2_BASE;
         assign hi10   = {words[(B + tlas_pkg::LIM_OFS_HI_MSB)*8 +: 8],
                          words[(B + tlas_pkg::LIM_OFS_HI_LSB)*8 + 6 +: 2]};
         assign lo10   = {words[(B + tlas_pkg::LIM_OFS_LO_MSB)*8 +: 8],
                          words[(B + tlas_pkg::LIM_OFS_LO_LSB)*8 + 6 +: 2]};
         assign crit10 = {words[(B + tlas_pkg::LIM_OFS_CRIT)*8 +: 8], tlas_pkg::FRAC_ZERO};
      end
      assign eval_v[ch]  = CONV_VALID_I && 32'(CONV_CHAN_I) == ch;
      assign over_v[ch]  = CONV_TEMP_I > hi10;
      assign under_v[ch] = CONV_TEMP_I <= lo10;
      assign crit_v[ch]  = CONV_TEMP_I > crit10;
      // Adding hysteresis to the sample avoids an underflow on the limit
      assign meas_h   = {1'b0, CONV_TEMP_I} + {1'b0, hyst_q, tlas_pkg::FRAC_ZERO};
      assign crit_rel = meas_h < {1'b0, crit10};
      assign th2_rel  = meas_h < {1'b0, hi10};
      assign clr      = (ch == 2) ? rd_s2 : rd_s1;
      assign over_c   = eval_v[ch] ? over_v[ch] : over_cq;
      assign under_c  = eval_v[ch] ? under_v[ch] : under_cq;
      assign open_c   = (ch == 0) ? 1'b0 : (eval_v[ch] ? CONV_OPEN_I : open_cq);

      // Next flag values: a new trip wins over a read in the same cycle
      always_comb
      begin
         over_f_d  = (eval_v[ch] && over_v[ch]) || (over_f[ch] && !(clr && !over_c));
         under_f_d = (eval_v[ch] && under_v[ch]) || (under_f[ch] && !(clr && !under_c));
         open_f_d  = (ch != 0) && ((eval_v[ch] && CONV_OPEN_I) ||
                                   (open_f[ch] && !(clr && !open_c)));
         crit_d    = crit_q[ch];
         th2_d     = th2_q[ch];
         if (eval_v[ch])
         begin
            crit_d = crit_v[ch] || (crit_q[ch] && !crit_rel);
            th2_d  = over_v[ch] || (th2_q[ch] && !th2_rel);
         end
      end

      always_ff @(posedge CLOCK_I)
      begin
         if (SYS_RST_I)
         begin
            over_f[ch]  <= 1'b0;
            under_f[ch] <= 1'b0;
            open_f[ch]  <= 1'b0;
            crit_q[ch]  <= 1'b0;
            th2_q[ch]   <= 1'b0;
            over_cq     <= 1'b0;
            under_cq    <= 1'b0;
            open_cq     <= 1'b0;
         end
         else
         begin
            over_f[ch]  <= over_f_d;
            under_f[ch] <= under_f_d;
            open_f[ch]  <= open_f_d;
            crit_q[ch]  <= crit_d;
            th2_q[ch]   <= th2_d;
            over_cq     <= over_c;
            under_cq    <= under_c;
            open_cq     <= open_c;
         end
      end
   end

   // Remote masks cover limit trips only, not open sensors
   assign unmasked = over_f[0] || under_f[0] || open_f[1] || open_f[2] ||
                     ((over_f[1] || under_f[1]) && !cfg_q[tlas_pkg::CFG_REMOTE_ONE_IRQ_SUPPRESS]) ||
                     ((over_f[2] || under_f[2]) && !cfg_q[tlas_pkg::CFG_REMOTE_TWO_IRQ_SUPPRESS]);

   assign stat1 = {CONV_BUSY_I, over_f[0], under_f[0], over_f[1], under_f[1],
                   open_f[1], crit_q[1], crit_q[0]};
   assign stat2 = {3'h0, over_f[2], under_f[2], open_f[2], crit_q[2], alert_q};

   // Rate code above the fastest step runs at the fastest step
   assign rate_eff = (rate_q[3:0] > tlas_pkg::RATE_FASTEST) ? tlas_pkg::RATE_FASTEST
                                                             : rate_q[3:0];
   assign period   = CNT_W'(SLOW_PERIOD_CYC >> rate_eff);

   // Control registers, read path, alert latch and conversion timer
   always_comb
   begin
      cfg_d    = cfg_q;
      rate_d   = rate_q;
      hyst_d   = hyst_q;
      rdata_d  = rdata_q;
      rd_d_mem = rd_mem_q;
      cnt_d    = cnt_q + CNT_W'(1);
      start_d  = 1'b0;
      alert_d  = alert_q;
      if (REG_WR_I)
      begin
         case (REG_ADDR_I)
            tlas_pkg::ADDR_CFG_WR:  cfg_d  = REG_WDATA_I & tlas_pkg::CFG_WR_MASK;
            tlas_pkg::ADDR_RATE_WR: rate_d = REG_WDATA_I & tlas_pkg::RATE_WR_MASK;
            tlas_pkg::ADDR_HYST:    hyst_d = REG_WDATA_I;
            default:                cfg_d  = cfg_q;       // Status writes dropped
         endcase
      end
      if (REG_RD_I)
      begin
         rd_d_mem = is_lim;
         case (REG_ADDR_I)
            tlas_pkg::ADDR_STAT1:   rdata_d = stat1;
            tlas_pkg::ADDR_STAT2:   rdata_d = stat2;
            tlas_pkg::ADDR_CFG_RD:  rdata_d = cfg_q;
            tlas_pkg::ADDR_RATE_RD: rdata_d = rate_q;
            tlas_pkg::ADDR_HYST:    rdata_d = hyst_q;
            default:                rdata_d = 8'h00;
         endcase
      end
      if (REG_WR_I && REG_ADDR_I == tlas_pkg::ADDR_RATE_WR)
      begin
         cnt_d = '0;
      end
      else if (cnt_q >= period - CNT_W'(1))
      begin
         cnt_d   = '0;
         start_d = 1'b1;
      end
      if (mask_all || pin8_th2)
      begin
         alert_d = 1'b0;
      end
      else if (unmasked)
      begin
         alert_d = 1'b1;
      end
      else if (ALERT_ACK_I)
      begin
         alert_d = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         cfg_q    <= tlas_pkg::CFG_RST;
         rate_q   <= tlas_pkg::RATE_RST;
         hyst_q   <= tlas_pkg::HYST_RST;
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
         rd_mem_q <= 1'b0;
         cnt_q    <= '0;
         start_q  <= 1'b0;
         alert_q  <= 1'b0;
      end
      else
      begin
         cfg_q    <= cfg_d;
         rate_q   <= rate_d;
         hyst_q   <= hyst_d;
         rdata_q  <= rdata_d;
         rvalid_q <= REG_RD_I;
         rd_mem_q <= rd_d_mem;
         cnt_q    <= cnt_d;
         start_q  <= start_d;
         alert_q  <= alert_d;
      end
   end

   // Outputs; open-drain pins only ever pull low
   assign REG_RDATA_O  = rd_mem_q ? mem_rdata : rdata_q;
   assign REG_RVALID_O = rvalid_q;
   assign CONV_START_O = start_q;
   assign RANGE_EXT_O  = cfg_q[tlas_pkg::CFG_RANGE];
   assign STANDBY_O    = cfg_q[tlas_pkg::CFG_STANDBY];
   assign PIN8_O       = 1'b0;
   assign CRITICAL_TEMP_OUT_O      = 1'b0;
   assign CRITICAL_TEMP_OUT_OE_O   = |crit_q;
   assign PIN8_OE_O    = pin8_th2 ? |th2_q : alert_q;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SYS_RST_I);

   sequence local_over_s;
      eval_v[0] && over_v[0];
   endsequence

   sequence alert_cause_s;
      unmasked && !mask_all && !pin8_th2;
   endsequence

   critical_temp_out_trip_a: assert property (eval_v[0] && crit_v[0] |=> CRITICAL_TEMP_OUT_OE_O [*1])
      else $error("Critical trip did not pull critical output");
   hyst_hold_a: assert property (crit_q[1] && !(eval_v[1] && g_ch[1].crit_rel)
                                 |=> crit_q[1])
      else $error("Critical flag released above hysteresis point");
   high_cmp_a: assert property (local_over_s |=> over_f[0])
      else $error("High trip not flagged");
   low_eq_a: assert property (eval_v[0] && CONV_TEMP_I == g_ch[0].lo10 |=> under_f[0])
      else $error("Low limit equality not flagged");
   status_ro_a: assert property (REG_WR_I && REG_ADDR_I == tlas_pkg::ADDR_STAT1
                                 && !CONV_VALID_I && !REG_RD_I |=> $stable(stat1[6:0]))
      else $error("Status write changed flags");
   sticky_hold_a: assert property (over_f[0] && !rd_s1 |=> over_f[0] ##1 (over_f[0] || rd_s1
                                   || $past(rd_s1)))
      else $error("Sticky flag dropped without read");
   alert_pull_a: assert property (alert_cause_s |=> PIN8_OE_O && stat2[0])
      else $error("Unmasked flag did not pull interrupt");
   alert_keep_a: assert property (alert_q && !ALERT_ACK_I && !mask_all && !pin8_th2
                                  |=> alert_q)
      else $error("Interrupt latch lost without alert response");
   mask_clear_a: assert property (mask_all |=> !PIN8_OE_O || pin8_th2)
      else $error("Masked interrupt still asserted");
   s2_alert_a: assert property (rd_s2 |=> REG_RDATA_O[0] == $past(alert_q))
      else $error("Secondary bit 0 does not mirror interrupt");
   th2_mode_a: assert property (pin8_th2 && eval_v[0] && over_v[0]
                                |=> PIN8_OE_O || !pin8_th2)
      else $error("Second critical output not driven");
   rate_rst_a: assert property ($fell(SYS_RST_I) |-> rate_q == tlas_pkg::RATE_RST)
      else $error("Rate register not at default");
endmodule
`default_nettype wire

// ### verification/tlas_host_model.sv
`default_nettype none
module tlas_host_model (
   input  wire logic       clk_i,
   output logic      [7:0] addr_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] wdata_o,
   output logic            ack_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Bus idle at time zero
   initial
   begin
      addr_o  = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      wdata_o = 8'h00;
      ack_o   = 1'b0;
   end

   // One strobe cycle; released lines show the inverse so stale values never match
   task automatic strobe(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= (a == 8'h0A) ? (d & 8'h0F) : d;
      wr_o    <= w;
      rd_o    <= ~w;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      rd_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      strobe(a, d, 1'b1);
   endtask

   task automatic rd(input logic [7:0] a);
      strobe(a, 8'h00, 1'b0);
   endtask

   // Alert response: host has read this device's address
   task automatic alert_ack;
      @(posedge clk_i);
      ack_o <= 1'b1;
      @(posedge clk_i);
      ack_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### verification/tlas_core_test.sv
`default_nettype none
module tlas_core_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned SLOW = 4096;
   localparam logic [7:0] KNOWN [13] = '{8'h50, 8'h10, 8'h55, 8'h7F, 8'h00, 8'h00,
      8'h00, 8'h55, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h55};
   logic       clk, rst, wr, rd, ack, cv, copen, cbusy, rvalid, start;
   logic       rext, stby, p8, p8_oe, th, th_oe;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] cch;
   logic [9:0] ctemp;
   logic [7:0] lim [13];
   logic [7:0] exp_q [$];
   logic [7:0] adr_q [$];
   int         n_errors, cmp_count, seed;

   tlas_core #(.SLOW_PERIOD_CYC(SLOW)) u_dut (
      .CLOCK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
      .ALERT_ACK_I(ack), .CONV_VALID_I(cv), .CONV_CHAN_I(cch), .CONV_TEMP_I(ctemp),
      .CONV_OPEN_I(copen), .CONV_BUSY_I(cbusy), .CONV_START_O(start),
      .RANGE_EXT_O(rext), .STANDBY_O(stby), .PIN8_O(p8), .PIN8_OE_O(p8_oe),
      .CRITICAL_TEMP_OUT_O(th), .CRITICAL_TEMP_OUT_OE_O(th_oe));

   tlas_host_model u_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata), .ack_o(ack));

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Read with the expected answer noted for the monitor
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      adr_q.push_back(a);
      u_host.rd(a);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Conversion result; waits past flag and latch update
   task automatic conv(input logic [1:0] ch, input int deg, input logic op);
      @(posedge clk);
      cv    <= 1'b1;
      cch   <= ch;
      ctemp <= {8'(deg), 2'b00};
      copen <= op;
      @(posedge clk);
      cv    <= 1'b0;
      ctemp <= ~ctemp;
      settle(3);
   endtask

   // Each read answer is paired with the oldest note
   always @(posedge clk)
   begin
      if (rvalid === 1'b1)
         chk($sformatf("reg %h", adr_q.pop_front()), rdata, exp_q.pop_front());
   end

   // Hang guard, well beyond the longest rate sweep
   initial
   begin
      #(40000 * 25);
      n_errors++;
      summarize();
   end

   initial
   begin
      int n;
      int h;
      seed  = 30;
      n_errors = 0;
      cmp_count = 0;
      rst   = 1'b1;
      cv    = 1'b0;
      cch   = 2'h0;
      ctemp = 10'h000;
      copen = 1'b0;
      cbusy = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chk("pin drive", {p8, p8_oe, th, th_oe}, 16'h0000);
      rc(8'h02, 8'h80);
      cbusy <= 1'b0;
      rc(8'h04, 8'h07);
      rc(8'h21, 8'h0A);
      rc(8'h03, 8'h00);
      u_host.wr(8'h02, 8'hFF);
      u_host.wr(8'h23, 8'hFF);
      u_host.wr(8'h04, 8'h03);
      rc(8'h02, 8'h00);
      rc(8'h23, 8'h00);
      rc(8'h04, 8'h07);
      rc(8'h7E, 8'h00);
      // Random hysteresis and limit bank, then a known bank
      h = $random(seed);
      u_host.wr(8'h21, 8'(h));
      rc(8'h21, 8'(h));
      u_host.wr(8'h21, 8'h0A);
      for (int i = 0; i < 13; i++)
      begin
         lim[i] = 8'($random(seed));
         if (i > 2 && ((i - 3) % 5 == 1 || (i - 3) % 5 == 3))
            lim[i] = lim[i] & 8'hC0;
         u_host.wr(8'h40 + 8'(i), lim[i]);
      end
      for (int i = 0; i < 13; i++)
         rc(8'h40 + 8'(i), lim[i]);
      for (int i = 0; i < 13; i++)
         u_host.wr(8'h40 + 8'(i), KNOWN[i]);
      // Rate codes 0 to 10: period halves per step
      for (int c = 0; c <= 10; c++)
      begin
         u_host.wr(8'h0A, 8'(c));
         rc(8'h04, 8'(c));
         n = 0;
         while (start !== 1'b1 && n < 5000)
         begin
            @(posedge clk);
            n++;
         end
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end while (start !== 1'b1 && n < 5000);
         chk("start period", 16'(n), 16'(SLOW >> c));
      end
      // Local over and under edges, sticky flags, latch service
      conv(2'h0, 17, 1'b0);
      conv(2'h0, 80, 1'b0);
      rc(8'h02, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         conv(2'h0, k ? 16 : 81, 1'b0);
         chk("alert pin", p8_oe, 16'h1);
         rc(8'h23, 8'h01);
         rc(8'h02, k ? 8'h20 : 8'h40);
         rc(8'h02, k ? 8'h20 : 8'h40);
         conv(2'h0, 50, 1'b0);
         rc(8'h02, k ? 8'h20 : 8'h40);
         rc(8'h02, 8'h00);
         settle(2);
         chk("alert held", p8_oe, 16'h1);
         u_host.alert_ack();
         settle(3);
         chk("alert cleared", p8_oe, 16'h0);
         rc(8'h23, 8'h00);
      end
      // Critical output with two hysteresis values on both remotes
      for (int ch = 1; ch <= 2; ch++)
      begin
         h = 5 * ch;
         u_host.wr(8'h21, 8'(h));
         conv(2'(ch), 86, 1'b0);
         chk("crit set", th_oe, 16'h1);
         rc(ch == 1 ? 8'h02 : 8'h23, 8'h02);
         conv(2'(ch), 85 - h, 1'b0);
         chk("crit held", th_oe, 16'h1);
         conv(2'(ch), 84 - h, 1'b0);
         chk("crit released", {p8_oe, th_oe}, 16'h0);
         rc(ch == 1 ? 8'h02 : 8'h23, 8'h00);
      end
      // Masks: remote one, remote two, all
      u_host.wr(8'h43, 8'h50);
      for (int k = 0; k < 3; k++)
      begin
         h = (k == 0) ? 8'h02 : ((k == 1) ? 8'h01 : 8'h80);
         u_host.wr(8'h09, 8'(h));
         conv(2'h1, 81, 1'b0);
         chk("masked alert", p8_oe, 16'(k == 1));
         rc(8'h23, 8'(k == 1));
         conv(2'h1, 50, 1'b0);
         rc(8'h02, 8'h10);
         rc(8'h02, 8'h00);
         u_host.wr(8'h09, 8'h00);
         u_host.alert_ack();
         settle(3);
         chk("alert idle", p8_oe, 16'h0);
      end
      // Open sensor raises an alert and survives until serviced
      conv(2'h2, 50, 1'b1);
      rc(8'h23, 8'h05);
      conv(2'h2, 50, 1'b0);
      rc(8'h23, 8'h05);
      rc(8'h23, 8'h01);
      u_host.alert_ack();
      settle(3);
      rc(8'h23, 8'h00);
      // Pin 8 as second critical output, high limits only
      u_host.wr(8'h09, 8'h20);
      rc(8'h03, 8'h20);
      for (int k = 0; k < 4; k++)
      begin
         conv(2'h0, (k == 0) ? 5 : ((k == 1) ? 81 : 75 - 2 * k), 1'b0);
         chk("second crit", p8_oe, 16'(k == 1 || k == 2));
      end
      rc(8'h02, 8'h60);
      u_host.wr(8'h09, 8'h00);
      settle(3);
      chk("pin8 back", p8_oe, 16'h0);
      // Extended range leaves stored limits untouched; reserved bit reads zero
      u_host.wr(8'h09, 8'h54);
      settle(2);
      chk("range out", {stby, rext}, 16'h3);
      rc(8'h03, 8'h44);
      rc(8'h40, 8'h50);
      u_host.wr(8'h40, 8'hD0);
      settle(4);
      summarize();
   end
endmodule
`default_nettype wire
